// >>> core/ppl_pkg.sv
// Shared constants and types for the transceiver configuration bank.
package ppl_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [11:0] IDX_SUPPLY_LEVEL_STATUS = 12'h0421;
  localparam logic [11:0] IDX_DEEP_SLEEP_CONTROL = 12'h0428;
  localparam logic [11:0] IDX_EQUALIZER_CONFIG_SIX = 12'h0450;
  localparam logic [11:0] IDX_GENERAL_CONFIG = 12'h0456;
  localparam logic [11:0] IDX_INDICATOR_CONFIG_ONE = 12'h0460;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SUP_AVDD_BIT = 2;
  localparam int DSC_PATTERN_MSB_BIT = 5;
  localparam int DSC_TEST_MODE_BIT = 4;
  localparam int DSC_SPEED_BIT = 3;
  localparam int DSC_ENABLE_BIT = 2;
  localparam int EQC_BYPASS_BIT = 13;
  localparam int GEN_MIN_IPG_BIT = 3;
  localparam int IND_ONE_LSB = 8;
  localparam int IND_THREE_LSB = 4;

  // ------------------------------------------------------------------
  // Writable masks and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] DSC_WR_MASK = 16'h003F;
  localparam logic [15:0] DSC_RESET = 16'h0000;
  localparam logic [15:0] EQC_RESET = 16'h0141;
  localparam logic [15:0] GEN_RESET = 16'h0008;
  localparam logic [15:0] IND_WR_MASK = 16'h0FFF;
  localparam logic [15:0] IND_RESET = 16'h0551;

  // ------------------------------------------------------------------
  // Indicator source codes
  // ------------------------------------------------------------------
  localparam logic [3:0] IND_LINK_GOOD = 4'h0;
  localparam logic [3:0] IND_ACTIVITY = 4'h1;
  localparam logic [3:0] IND_TX_ACTIVITY = 4'h2;
  localparam logic [3:0] IND_RX_ACTIVITY = 4'h3;
  localparam logic [3:0] IND_COLLISION = 4'h4;
  localparam logic [3:0] IND_SPEED_100 = 4'h5;
  localparam logic [3:0] IND_SPEED_10 = 4'h6;
  localparam logic [3:0] IND_FULL_DUPLEX = 4'h7;
  localparam logic [3:0] IND_LINK_BLINK = 4'h8;
  localparam logic [3:0] IND_STRETCH = 4'h9;
  localparam logic [3:0] IND_LINK_100_FD = 4'hA;
  localparam logic [3:0] IND_LOW_POWER_IDLE = 4'hB;
  localparam logic [3:0] IND_MII_ERROR = 4'hC;
  localparam logic [3:0] IND_LINK_LOST = 4'hD;
  localparam logic [3:0] IND_TEST_ERROR = 4'hE;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_KHZ = 40_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int EXIT_FAST_MS = 50;
  localparam int EXIT_SLOW_MS = 100;
  localparam int EXIT_FAST_CYCLES = EXIT_FAST_MS * CLK_KHZ;
  localparam int EXIT_SLOW_CYCLES = EXIT_SLOW_MS * CLK_KHZ;
  localparam int IPG_MIN_NS = 120;
  localparam int IPG_STD_NS = 200;
  localparam logic [3:0] IPG_MIN_CYCLES =
    4'((IPG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] IPG_STD_CYCLES =
    4'((IPG_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int TIMER_WIDTH = 22;

  // ------------------------------------------------------------------
  // Bus responses and sleep states
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SLP_AWAKE = 2'b00,
    SLP_DEEP = 2'b01,
    SLP_EXIT = 2'b10
  } ppl_sleep_type;

endpackage : ppl_pkg

// >>> core/ppl_exit_timer.sv
// Down counter that times the exit from deep sleep.
`timescale 1ns/1ps
module ppl_exit_timer
  import ppl_pkg::*;
#(
  parameter int WIDTH = TIMER_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [WIDTH-1:0] loadValue,
  // Status
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] count_r;
  logic busy_r;
  logic done_r;
  wire lastCycle = busy_r && (count_r == WIDTH'(1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= lastCycle && !abort && !start;
      if (abort) begin
        busy_r <= 1'b0;
      end else if (start) begin
        count_r <= loadValue;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        count_r <= count_r - WIDTH'(1);
        busy_r <= !lastCycle;
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;

endmodule : ppl_exit_timer

// >>> core/ppl_indicator.sv
// Source selector for one indicator output.
`timescale 1ns/1ps
module ppl_indicator
  import ppl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Selection
  input wire logic [3:0] sourceSel,
  input wire logic [14:0] sources,
  // Output
  output logic lit
);

  logic lit_r;
  // Code 1111 has no source and keeps the output dark.
  wire litNxt = (sourceSel == 4'hF) ? 1'b0 : sources[sourceSel];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lit_r <= 1'b0;
    end else if (ce) begin
      lit_r <= litNxt;
    end
  end

  assign lit = lit_r;

endmodule : ppl_indicator

// >>> core/ppl_config_bank.sv
// Power, test-pattern and indicator configuration bank with AXI4-Lite access.
//
// Behaviour
// - Pattern length is 5 bits; N zeros follow each one; zero clears pattern.
// - Test-mode bit one sends idle pattern; zero transmits normally; resets zero.
// - Speed bit one exits deep sleep in 50 ms; zero in 100 ms.
// - Writing one to deep sleep enable enters deep sleep; resets to zero.
// - Equalizer bypass bit one skips calibration; resets to zero.
// - Minimum gap bit resets one for 120 ns; zero gives 200 ns.
// - Bits 11:8 select indicator one source; reset 0101; codes 0 to 7.
// - Codes 8 to 14 select blink, stretch, 100FD, idle, errors; 15 reserved.
// - Link-lost indicator stays lit until basic mode register is read.
// - Test-error indicator latches on one error until self-test register cleared.
// - Bits 7:4 select indicator three on receive data bit three pin.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ppl_config_bank
  import ppl_pkg::*;
#(
  parameter int ADDR_WIDTH = 16,
  parameter int EXIT_FAST = EXIT_FAST_CYCLES,
  parameter int EXIT_SLOW = EXIT_SLOW_CYCLES,
  parameter int BLINK_HALF = 2048,
  parameter int STRETCH_LEN = 4095
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Supply detection
  input wire logic avddLevel,
  input wire logic [1:0] vddioLevel,
  // Test pattern low bits and management events
  input wire logic [3:0] idlePatternLow,
  input wire logic basicStatusRead,
  input wire logic selfTestClear,
  // Link status sources
  input wire logic linkGood,
  input wire logic activity,
  input wire logic txActivity,
  input wire logic rxActivity,
  input wire logic collision,
  input wire logic speed100,
  input wire logic speed10,
  input wire logic fullDuplex,
  input wire logic lowPowerIdle,
  input wire logic miiError,
  input wire logic prbsError,
  // Transmit test pattern
  output logic idleTestActive,
  output logic idleTestBit,
  // Power and datapath controls
  output logic deepSleepActive,
  output logic deepSleepExiting,
  output logic eqCalBypass,
  output logic [3:0] ipgGapCycles,
  // Indicators
  output logic indicatorOne,
  output logic receiveDataBitThreePin
);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [15:0] deepCtl_r;
  logic [15:0] eqCfg_r;
  logic [15:0] general_config_r;
  logic [15:0] indCfg_r;

  // ------------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------------
  logic awHeld_r;
  logic wHeld_r;
  logic [11:0] awIdx_r;
  logic [15:0] wData_r;
  logic [1:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire [11:0] awIdxNow = s_axi_awaddr[13:2];
  wire awBad = |s_axi_awaddr[ADDR_WIDTH-1:14];
  wire [11:0] wrIdx = awHeld_r ? awIdx_r : awIdxNow;
  wire [15:0] wrData = wHeld_r ? wData_r : s_axi_wdata[15:0];
  wire [1:0] wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb[1:0];
  wire haveAw = awHeld_r || awTake;
  wire haveW = wHeld_r || wTake;
  wire doWrite = haveAw && haveW && !bValid_r;
  wire [15:0] byteMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
  logic awBad_r;
  wire wrBad = awHeld_r ? awBad_r : awBad;

  wire selWrDeep = !wrBad && (wrIdx == IDX_DEEP_SLEEP_CONTROL);
  wire selWrEq = !wrBad && (wrIdx == IDX_EQUALIZER_CONFIG_SIX);
  wire selWrGen = !wrBad && (wrIdx == IDX_GENERAL_CONFIG);
  wire selWrInd = !wrBad && (wrIdx == IDX_INDICATOR_CONFIG_ONE);
  wire selWrSup = !wrBad && (wrIdx == IDX_SUPPLY_LEVEL_STATUS);
  wire wrMapped = selWrDeep || selWrEq || selWrGen || selWrInd || selWrSup;

  // Reserved read-only bits are outside the write masks.
  wire [15:0] deepMask = byteMask & DSC_WR_MASK;
  wire [15:0] indMask = byteMask & IND_WR_MASK;
  wire [15:0] deepCtlNxt = (deepCtl_r & ~deepMask) | (wrData & deepMask);
  wire [15:0] eqCfgNxt = (eqCfg_r & ~byteMask) | (wrData & byteMask);
  wire [15:0] genCfgNxt = (general_config_r & ~byteMask) | (wrData & byteMask);
  wire [15:0] indCfgNxt = (indCfg_r & ~indMask) | (wrData & indMask);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awIdx_r <= '0;
      awBad_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (awTake) begin
          awHeld_r <= 1'b1;
          awIdx_r <= awIdxNow;
          awBad_r <= awBad;
        end
        if (wTake) begin
          wHeld_r <= 1'b1;
          wData_r <= s_axi_wdata[15:0];
          wStrb_r <= s_axi_wstrb[1:0];
        end
        if (bValid_r && s_axi_bready) begin
          bValid_r <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deepCtl_r <= DSC_RESET;
      eqCfg_r <= EQC_RESET;
      general_config_r <= GEN_RESET;
      indCfg_r <= IND_RESET;
    end else if (ce && doWrite) begin
      if (selWrDeep) deepCtl_r <= deepCtlNxt;
      if (selWrEq) eqCfg_r <= eqCfgNxt;
      if (selWrGen) general_config_r <= genCfgNxt;
      if (selWrInd) indCfg_r <= indCfgNxt;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------------
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;

  assign s_axi_arready = !rValid_r;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire [11:0] rdIdx = s_axi_araddr[13:2];
  wire rdBad = |s_axi_araddr[ADDR_WIDTH-1:14];
  wire [15:0] supplyWord = {13'h0000, avddLevel, vddioLevel};
  wire selRdSup = !rdBad && (rdIdx == IDX_SUPPLY_LEVEL_STATUS);
  wire selRdDeep = !rdBad && (rdIdx == IDX_DEEP_SLEEP_CONTROL);
  wire selRdEq = !rdBad && (rdIdx == IDX_EQUALIZER_CONFIG_SIX);
  wire selRdGen = !rdBad && (rdIdx == IDX_GENERAL_CONFIG);
  wire selRdInd = !rdBad && (rdIdx == IDX_INDICATOR_CONFIG_ONE);
  wire rdMapped = selRdSup || selRdDeep || selRdEq || selRdGen || selRdInd;
  wire [15:0] rdWord = ({16{selRdSup}} & supplyWord)
                     | ({16{selRdDeep}} & deepCtl_r)
                     | ({16{selRdEq}} & eqCfg_r)
                     | ({16{selRdGen}} & general_config_r)
                     | ({16{selRdInd}} & indCfg_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        rValid_r <= 1'b1;
        rData_r <= {16'h0000, rdWord};
        rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_r && s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // ------------------------------------------------------------------
  // Idle pattern generator
  // ------------------------------------------------------------------
  wire testMode = deepCtl_r[DSC_TEST_MODE_BIT];
  wire [4:0] patternLen = {deepCtl_r[DSC_PATTERN_MSB_BIT], idlePatternLow};
  wire patternClear = (patternLen == 5'h00);
  logic [4:0] patCount_r;
  logic patBit_r;
  wire patWrap = (patCount_r >= patternLen);
  wire [4:0] patCountNxt = patWrap ? 5'h00 : patCount_r + 5'h01;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      patCount_r <= 5'h00;
      patBit_r <= 1'b0;
    end else if (ce) begin
      if (!testMode || patternClear) begin
        patCount_r <= 5'h00;
        patBit_r <= 1'b0;
      end else begin
        patCount_r <= patCountNxt;
        patBit_r <= (patCount_r == 5'h00);
      end
    end
  end

  assign idleTestActive = testMode;
  assign idleTestBit = patBit_r;

  // ------------------------------------------------------------------
  // Deep sleep sequencing
  // ------------------------------------------------------------------
  ppl_sleep_type sleep_r;
  ppl_sleep_type sleepNxt;
  // Entry assumes standard power-down was already requested elsewhere.
  wire sleepReq = deepCtl_r[DSC_ENABLE_BIT];
  wire exitFast = deepCtl_r[DSC_SPEED_BIT];
  wire timerDone;
  wire [TIMER_WIDTH-1:0] exitLoad = exitFast ? TIMER_WIDTH'(EXIT_FAST)
                                             : TIMER_WIDTH'(EXIT_SLOW);
  wire startExit = (sleep_r == SLP_DEEP) && !sleepReq;
  wire abortExit = (sleep_r == SLP_EXIT) && sleepReq;

  always_comb begin
    sleepNxt = sleep_r;
    unique case (sleep_r)
      SLP_AWAKE: begin
        if (sleepReq) sleepNxt = SLP_DEEP;
      end
      SLP_DEEP: begin
        if (!sleepReq) sleepNxt = SLP_EXIT;
      end
      SLP_EXIT: begin
        if (sleepReq) sleepNxt = SLP_DEEP;
        else if (timerDone) sleepNxt = SLP_AWAKE;
      end
      default: sleepNxt = SLP_AWAKE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_r <= SLP_AWAKE;
    end else if (ce) begin
      sleep_r <= sleepNxt;
    end
  end

  ppl_exit_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_exit_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(startExit),
    .abort(abortExit),
    .loadValue(exitLoad),
    .busy(),
    .done(timerDone)
  );

  assign deepSleepActive = (sleep_r != SLP_AWAKE);
  assign deepSleepExiting = (sleep_r == SLP_EXIT);

  // ------------------------------------------------------------------
  // Datapath controls
  // ------------------------------------------------------------------
  assign eqCalBypass = eqCfg_r[EQC_BYPASS_BIT];
  // Software keeps the long gap unless the MAC side runs MII.
  assign ipgGapCycles = general_config_r[GEN_MIN_IPG_BIT] ? IPG_MIN_CYCLES
                                                  : IPG_STD_CYCLES;

  // ------------------------------------------------------------------
  // Indicator sources
  // ------------------------------------------------------------------
  logic linkPrev_r;
  logic linkLost_r;
  logic testErr_r;
  logic [11:0] blinkCnt_r;
  logic blinkPhase_r;
  logic [11:0] stretchCnt_r;
  wire linkDrop = linkPrev_r && !linkGood;
  wire blinkWrap = (blinkCnt_r >= 12'(BLINK_HALF - 1));

  // A new event in the clearing cycle keeps the latch set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkPrev_r <= 1'b0;
      linkLost_r <= 1'b0;
      testErr_r <= 1'b0;
    end else if (ce) begin
      linkPrev_r <= linkGood;
      if (linkDrop) linkLost_r <= 1'b1;
      else if (basicStatusRead) linkLost_r <= 1'b0;
      if (prbsError) testErr_r <= 1'b1;
      else if (selfTestClear) testErr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blinkCnt_r <= 12'h000;
      blinkPhase_r <= 1'b0;
      stretchCnt_r <= 12'h000;
    end else if (ce) begin
      blinkCnt_r <= blinkWrap ? 12'h000 : blinkCnt_r + 12'h001;
      if (blinkWrap) blinkPhase_r <= !blinkPhase_r;
      if (activity) stretchCnt_r <= 12'(STRETCH_LEN);
      else if (stretchCnt_r != 12'h000) stretchCnt_r <= stretchCnt_r - 12'h001;
    end
  end

  wire [14:0] indSources;
  assign indSources[IND_LINK_GOOD] = linkGood;
  assign indSources[IND_ACTIVITY] = activity;
  assign indSources[IND_TX_ACTIVITY] = txActivity;
  assign indSources[IND_RX_ACTIVITY] = rxActivity;
  assign indSources[IND_COLLISION] = collision;
  assign indSources[IND_SPEED_100] = speed100;
  assign indSources[IND_SPEED_10] = speed10;
  assign indSources[IND_FULL_DUPLEX] = fullDuplex;
  assign indSources[IND_LINK_BLINK] =
    linkGood && !(activity && blinkPhase_r);
  assign indSources[IND_STRETCH] = activity || (stretchCnt_r != 12'h000);
  assign indSources[IND_LINK_100_FD] = linkGood && speed100 && fullDuplex;
  assign indSources[IND_LOW_POWER_IDLE] = lowPowerIdle;
  assign indSources[IND_MII_ERROR] = miiError;
  assign indSources[IND_LINK_LOST] = linkLost_r;
  assign indSources[IND_TEST_ERROR] = testErr_r;

  // ------------------------------------------------------------------
  // Indicator outputs
  // ------------------------------------------------------------------
  wire [7:0] indSelAll = {indCfg_r[IND_ONE_LSB +: 4],
                          indCfg_r[IND_THREE_LSB +: 4]};
  wire [1:0] indLit;

  for (genvar g = 0; g < 2; g++) begin : g_ind
    ppl_indicator u_ind (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .sourceSel(indSelAll[g*4 +: 4]),
      .sources(indSources),
      .lit(indLit[g])
    );
  end

  assign indicatorOne = indLit[1];
  assign receiveDataBitThreePin = indLit[0];

endmodule : ppl_config_bank

// >>> verification/ppl_config_bank_properties.sv
// Port assertions for the configuration bank.
`timescale 1ns/1ps
module ppl_config_bank_properties #(
  parameter int EXIT_SLOW = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Device controls
  input wire logic [3:0] idlePatternLow,
  input wire logic idleTestActive,
  input wire logic idleTestBit,
  input wire logic deepSleepActive,
  input wire logic deepSleepExiting,
  input wire logic [3:0] ipgGapCycles
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Counts the cycles spent leaving deep sleep.
  int exitCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) exitCnt <= 0;
    else exitCnt <= deepSleepExiting ? exitCnt + 1 : 0;
  end
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rlat;
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rsvd;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper half set");
  property p_ipg;
    ipgGapCycles == 4'h5 || ipgGapCycles == 4'h8;
  endproperty
  a_ipg: assert property (p_ipg) else $error("bad gap");
  property p_exact;
    $rose(deepSleepExiting) |-> $past(deepSleepActive);
  endproperty
  a_exact: assert property (p_exact) else $error("exit not asleep");
  property p_exlen;
    exitCnt <= EXIT_SLOW + 4;
  endproperty
  a_exlen: assert property (p_exlen) else $error("exit too long");
  property p_off;
    !idleTestActive ##1 !idleTestActive |-> !idleTestBit;
  endproperty
  a_off: assert property (p_off) else $error("pattern while off");
  property p_pat;
    idleTestBit && idlePatternLow != 4'h0 |=> !idleTestBit;
  endproperty
  a_pat: assert property (p_pat) else $error("no zero after one");
  c_exit: cover property ($fell(deepSleepExiting));
  c_pat: cover property ($rose(idleTestBit));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : ppl_config_bank_properties

bind ppl_config_bank ppl_config_bank_properties #(.EXIT_SLOW(EXIT_SLOW))
  ppl_config_bank_properties_i (.*);

// >>> verification/phy_power_test_led_config_tb_top.sv
// Self-checking testbench for the configuration bank.
`timescale 1ns/1ps
`define CHK(a, b) begin ev = b; checkCount++; if ((a) !== ev) begin \
  numErrors++; $display("ERROR t=%0t got %h exp %h", $time, a, ev); end end
module phy_power_test_led_config_tb_top;
  import ppl_pkg::*;
  logic clk, rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, prb;
  logic s_axi_arvalid, s_axi_rready, avddLevel, basicStatusRead;
  logic selfTestClear, linkGood, activity, txActivity, rxActivity;
  logic collision, speed100, speed10, fullDuplex, lowPowerIdle, miiError;
  logic prbsError, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, idleTestActive, idleTestBit, deepSleepActive, eb, ed;
  logic deepSleepExiting, eqCalBypass, indicatorOne, receiveDataBitThreePin;
  logic et;
  logic [15:0] s_axi_awaddr, s_axi_araddr, r, d;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, idlePatternLow, ipgGapCycles, eg;
  logic [1:0] s_axi_bresp, s_axi_rresp, vddioLevel;
  logic [10:0] src, s;
  logic [33:0] ev, rq[$];
  logic [1:0] bq[$];
  logic [8:0] pq[$];
  logic [7:0] cnt;
  int numErrors, checkCount, seed, n;
  assign {prbsError, miiError, lowPowerIdle, fullDuplex, speed10, speed100,
    collision, rxActivity, txActivity, activity, linkGood} = src;
  ppl_config_bank #(.EXIT_FAST(20), .EXIT_SLOW(40), .BLINK_HALF(4),
    .STRETCH_LEN(8)) ppl_config_bank_i (.*);
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready)
      `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
    if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, bq.pop_front())
    if (prb) `CHK({indicatorOne, receiveDataBitThreePin, eqCalBypass,
      ipgGapCycles, deepSleepActive, idleTestActive}, pq.pop_front())
  end
  function automatic logic [15:0] ad(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad
  function automatic logic lit(input int c, input logic [10:0] v);
    if (c == 10) return v[0] & v[5] & v[7];
    return c < 8 ? v[c] : c == 8 ? v[0] : c == 11 ? v[8] : c == 12 ? v[9] : 0;
  endfunction : lit
  task automatic bus(input bit w, input logic [15:0] a, dt,
                     input logic [33:0] e);
    bit da, dw, db, ta, tw, tb;
    if (w) bq.push_back(e[33:32]);
    else rq.push_back(e);
    @(posedge clk);
    {da, dw, db} = {1'b0, !w, 1'b0};
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {16'h0000, dt};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    while (!(da && dw && db)) begin
      @(negedge clk);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      @(posedge clk);
      if (!da && ta) begin
        da = 1;
        {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      end
      if (!dw && tw) begin
        dw = 1;
        s_axi_wvalid <= 0;
      end
      if (!db && tb) begin
        db = 1;
        {s_axi_bready, s_axi_rready} <= 2'b00;
      end
    end
  endtask : bus
  task automatic probe(input logic [1:0] li);
    pq.push_back({li, eb, eg, ed, et});
    @(posedge clk) prb <= 1;
    @(posedge clk) prb <= 0;
  endtask : probe
  task automatic finish_test();
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    numErrors++;
    finish_test();
  end
  initial begin
    {rst, ce, s_axi_wstrb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, prb, basicStatusRead, selfTestClear, src} = 0;
    {eb, eg, ed, et} = 7'h14;
    seed = 32'hdb82_35b8;
    {avddLevel, vddioLevel} = 3'($random(seed));
    idlePatternLow = 4'($random(seed)) | 4'h1;
    repeat (2) @(posedge clk);
    rst <= 0;
    src <= 11'($random(seed));
    bus(0, ad(IDX_SUPPLY_LEVEL_STATUS), 0, 34'({avddLevel, vddioLevel}));
    bus(0, ad(IDX_DEEP_SLEEP_CONTROL), 0, 34'h0000);
    bus(0, ad(IDX_EQUALIZER_CONFIG_SIX), 0, 34'h0141);
    bus(0, ad(IDX_GENERAL_CONFIG), 0, 34'h0008);
    bus(0, ad(IDX_INDICATOR_CONFIG_ONE), 0, 34'h0551);
    probe({2{src[5]}});
    bus(1, ad(IDX_DEEP_SLEEP_CONTROL), 16'hFFC3, 0);
    bus(0, ad(IDX_DEEP_SLEEP_CONTROL), 0, 34'h0003);
    bus(1, ad(IDX_SUPPLY_LEVEL_STATUS), 16'hFFFF, 0);
    bus(0, ad(IDX_SUPPLY_LEVEL_STATUS), 0, 34'({avddLevel, vddioLevel}));
    bus(1, 16'h0000, 16'h1234, {2'b10, 32'h0});
    bus(0, 16'h0000, 0, {2'b10, 32'h0});
    $display("reset and access done");
    r = 16'($random(seed)) | 16'h2000;
    bus(1, ad(IDX_EQUALIZER_CONFIG_SIX), r, 0);
    bus(0, ad(IDX_EQUALIZER_CONFIG_SIX), 0, 34'(r));
    bus(1, ad(IDX_GENERAL_CONFIG), r & 16'hFFF7, 0);
    bus(0, ad(IDX_GENERAL_CONFIG), 0, 34'(r & 16'hFFF7));
    {eb, eg} = 5'h18;
    probe({2{src[5]}});
    for (int c = 0; c < 16; c++) begin
      if (c == 13 || c == 14) continue;
      s = 11'($random(seed));
      if (c == 8 || c == 9) s[1] = 1'b0;
      src <= s;
      bus(1, ad(IDX_INDICATOR_CONFIG_ONE), {4'h0, 4'(c), 4'(c), 4'h1}, 0);
      repeat (12) @(posedge clk);
      probe({2{lit(c, s)}});
    end
    bus(1, ad(IDX_INDICATOR_CONFIG_ONE), 16'h0DE1, 0);
    src <= 11'h001;
    {basicStatusRead, selfTestClear} <= 2'b11;
    @(posedge clk) {basicStatusRead, selfTestClear} <= 2'b00;
    @(posedge clk) src <= 11'h400;
    @(posedge clk) src <= 11'h001;
    repeat (3) @(posedge clk);
    probe(2'b11);
    @(posedge clk) basicStatusRead <= 1;
    @(posedge clk) basicStatusRead <= 0;
    probe(2'b01);
    @(posedge clk) selfTestClear <= 1;
    @(posedge clk) selfTestClear <= 0;
    probe(2'b00);
    $display("indicators done");
    for (int k = 0; k < 2; k++) begin
      bus(1, ad(IDX_DEEP_SLEEP_CONTROL), k ? 16'h0004 : 16'h000C, 0);
      ed = 1;
      probe(2'b00);
      bus(1, ad(IDX_DEEP_SLEEP_CONTROL), k ? 16'h0000 : 16'h0008, 0);
      repeat (8) @(posedge clk);
      probe(2'b00);
      repeat (20) @(posedge clk);
      ed = 1'(k);
      probe(2'b00);
      repeat (20) @(posedge clk);
      ed = 0;
      probe(2'b00);
    end
    $display("deep sleep done");
    for (int k = 0; k < 4; k++) begin
      d = k == 1 ? 16'h0030 : k == 3 ? 16'h0000 : 16'h0010;
      if (k == 2) idlePatternLow <= 0;
      bus(1, ad(IDX_DEEP_SLEEP_CONTROL), d, 0);
      et = d[4];
      n = {d[5], idlePatternLow} + 1;
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (2 * n) @(negedge clk) cnt += idleTestBit;
      `CHK(cnt, (n > 1 && d[4]) ? 2 : 0)
      probe(2'b00);
    end
    $display("pattern done");
    finish_test();
  end
endmodule : phy_power_test_led_config_tb_top
